// >>> pkg/mpdp_pkg.sv
// Purpose: shared constants and types of the port data path
// Assumes: core clock of 200 MHz on both ends
// Notes: link clock periods come from the two documented rates
package mpdp_pkg;
  // nibble layout, bit 0 is the least significant
  localparam int NIBBLE_W = 4;
  localparam int NIBBLE_LSB = 0;
  localparam logic [NIBBLE_W-1:0] IDLE_NIBBLE = 4'h0;
  // clock rates in kHz
  localparam int CORE_CLK_KHZ = 200000;
  localparam int LINK_FAST_KHZ = 25000;
  localparam int LINK_SLOW_KHZ = 2500;
  // core cycles per half period of the link clocks
  localparam int DIV_W = 6;
  localparam logic [DIV_W-1:0] HALF_FAST = DIV_W'(CORE_CLK_KHZ / (2 * LINK_FAST_KHZ));
  localparam logic [DIV_W-1:0] HALF_SLOW = DIV_W'(CORE_CLK_KHZ / (2 * LINK_SLOW_KHZ));
  localparam logic [DIV_W-1:0] DIV_ONE = 6'h01;
  localparam logic [DIV_W-1:0] DIV_ZERO = 6'h00;
  // transmit path state, one-hot
  typedef enum logic [2:0] {
    TX_IDLE = 3'h1,
    TX_DATA = 3'h2,
    TX_HALT = 3'h4
  } mpdp_tx_state_t;
endpackage : mpdp_pkg

// >>> pkg/mpdp_if.sv
// Purpose: media independent pins between the port and its controller
// Assumes: all pins are point to point, no three-state sharing
// Notes: the port end sources both link clocks
`timescale 1ns/1ps
interface mpdp_if;
  import mpdp_pkg::*;
  logic portTxClock;
  logic [NIBBLE_W-1:0] portTxNibble;
  logic portTxEnable;
  logic portTxError;
  logic portRxClock;
  logic [NIBBLE_W-1:0] portRxNibble;
  logic portRxValid;
  logic portRxError;
  logic portCollision;
  logic portCarrierSense;

  modport phy (
    output portTxClock, portRxClock, portRxNibble, portRxValid, portRxError,
    output portCollision, portCarrierSense,
    input portTxNibble, portTxEnable, portTxError
  );

  modport mac (
    input portTxClock, portRxClock, portRxNibble, portRxValid, portRxError,
    input portCollision, portCarrierSense,
    output portTxNibble, portTxEnable, portTxError
  );
endinterface : mpdp_if

// >>> verilog/mpdp_phy_end.sv
// Purpose: port end of the media independent data path
// Assumes: line side runs on core_clk; speed and duplex come from outside
// Notes: link clocks are divided from core_clk and driven out
// Operation
// - port makes transmit clock, 2.5/25 MHz
// - port makes receive clock, 2.5/25 MHz
// - controller changes tx nibble on tx clock
// - tx nibble bit zero is least significant
// - only four tx nibble lines are sampled
// - controller holds tx enable with data
// - controller flags tx stream errors
// - tx error at 100 Mbps sends halt code
// - rx nibble changes with receive clock
// - rx valid marks exactly valid nibbles
// - rx error flags invalid line symbols
// - collision follows line, off in full duplex
// - carrier sense: tx or rx, rx only full
`timescale 1ns/1ps
module mpdp_phy_end (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // controller pins
  mpdp_if.phy link,
  // mode
  input wire logic speed100,
  input wire logic fullDuplex,
  // transmit toward the line
  output logic [mpdp_pkg::NIBBLE_W-1:0] lineTxNibble,
  output logic lineTxValid,
  output logic lineTxHalt,
  output logic lineTxStrobe,
  // receive from the line
  input wire logic [mpdp_pkg::NIBBLE_W-1:0] lineRxNibble,
  input wire logic lineRxValid,
  input wire logic lineRxSymbolError,
  input wire logic lineRxActive,
  input wire logic lineCollision,
  output logic lineRxTake
);
  import mpdp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // half period of a link clock in core cycles for the current speed
  function automatic logic [DIV_W-1:0] halfCount(input logic fast);
    halfCount = fast ? HALF_FAST : HALF_SLOW;
  endfunction : halfCount

  // last count before a link clock toggles
  function automatic logic atToggle(input logic [DIV_W-1:0] cnt, input logic fast);
    atToggle = (cnt >= halfCount(fast) - DIV_ONE);
  endfunction : atToggle

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [DIV_W-1:0] txDiv;
  logic [DIV_W-1:0] rxDiv;
  logic txClk;
  logic rxClk;
  logic txRise;
  logic rxFall;
  logic [NIBBLE_W-1:0] txNibbleMeta;
  logic [NIBBLE_W-1:0] txNibbleSync;
  logic txEnableMeta;
  logic txEnableSync;
  logic txErrorMeta;
  logic txErrorSync;
  logic [NIBBLE_W-1:0] rxNibble;
  logic rxValid;
  logic rxError;
  logic collision;
  logic carrierSense;
  mpdp_tx_state_t txState;
  mpdp_tx_state_t next_txState;

  assign link.portTxClock = txClk;
  assign link.portRxClock = rxClk;
  assign link.portRxNibble = rxNibble;
  assign link.portRxValid = rxValid;
  assign link.portRxError = rxError;
  assign link.portCollision = collision;
  assign link.portCarrierSense = carrierSense;

  ////////////////////////////////////////////////////////////////////////////
  // transmit clock divider

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      txDiv <= DIV_ZERO;
      txClk <= 1'h0;
    end else if (atToggle(txDiv, speed100)) begin
      txDiv <= DIV_ZERO;
      txClk <= ~txClk;
    end else begin
      txDiv <= txDiv + DIV_ONE;
    end
  end

  // cycle in which the transmit clock goes high
  assign txRise = atToggle(txDiv, speed100) && !txClk;

  ////////////////////////////////////////////////////////////////////////////
  // receive clock divider

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rxDiv <= DIV_ZERO;
      rxClk <= 1'h0;
    end else if (atToggle(rxDiv, speed100)) begin
      rxDiv <= DIV_ZERO;
      rxClk <= ~rxClk;
    end else begin
      rxDiv <= rxDiv + DIV_ONE;
    end
  end

  // cycle in which the receive clock goes low
  assign rxFall = atToggle(rxDiv, speed100) && rxClk;

  ////////////////////////////////////////////////////////////////////////////
  // controller pin synchronisers

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      txNibbleMeta <= IDLE_NIBBLE;
      txNibbleSync <= IDLE_NIBBLE;
      txEnableMeta <= 1'h0;
      txEnableSync <= 1'h0;
      txErrorMeta <= 1'h0;
      txErrorSync <= 1'h0;
    end else begin
      txNibbleMeta <= link.portTxNibble[NIBBLE_W-1:NIBBLE_LSB];
      txNibbleSync <= txNibbleMeta;
      txEnableMeta <= link.portTxEnable;
      txEnableSync <= txEnableMeta;
      txErrorMeta <= link.portTxError;
      txErrorSync <= txErrorMeta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit path state

  // the controller moves its pins just after a rising edge, so the
  // synchronised copy is settled by the next rising edge
  always_comb begin
    next_txState = txState;
    case (txState)
      TX_IDLE, TX_DATA, TX_HALT: begin
        if (txRise) begin
          if (!txEnableSync) begin
            next_txState = TX_IDLE;
          end else if (txErrorSync && speed100) begin
            next_txState = TX_HALT;
          end else begin
            next_txState = TX_DATA;
          end
        end
      end
      default: begin
        next_txState = TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      txState <= TX_IDLE;
    end else begin
      txState <= next_txState;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit toward the line

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      lineTxNibble <= IDLE_NIBBLE;
      lineTxValid <= 1'h0;
      lineTxHalt <= 1'h0;
      lineTxStrobe <= 1'h0;
    end else begin
      lineTxStrobe <= txRise;
      if (txRise) begin
        // error at 10 Mbps is ignored, data passes as is
        lineTxHalt <= txEnableSync && txErrorSync && speed100;
        lineTxValid <= txEnableSync;
        lineTxNibble <= txEnableSync ? txNibbleSync : IDLE_NIBBLE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive toward the controller

  // outputs move on the falling edge so they stand still at the rising one
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rxNibble <= IDLE_NIBBLE;
      rxValid <= 1'h0;
      rxError <= 1'h0;
      lineRxTake <= 1'h0;
    end else begin
      lineRxTake <= rxFall;
      if (rxFall) begin
        rxNibble <= lineRxValid ? lineRxNibble : IDLE_NIBBLE;
        rxValid <= lineRxValid;
        rxError <= lineRxSymbolError;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // collision and carrier sense

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      collision <= 1'h0;
    end else begin
      collision <= lineCollision && !fullDuplex;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      carrierSense <= 1'h0;
    end else if (fullDuplex) begin
      carrierSense <= lineRxActive;
    end else begin
      carrierSense <= lineRxActive || (txState != TX_IDLE);
    end
  end

endmodule : mpdp_phy_end

// >>> verilog/mpdp_mac_end.sv
// Purpose: controller end of the media independent data path
// Assumes: link clocks come from the port end and are sampled here
// Notes: data is driven after a rising tx clock, taken after a rising rx clock
`timescale 1ns/1ps
module mpdp_mac_end (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // port pins
  mpdp_if.mac link,
  // transmit from the user
  input wire logic [mpdp_pkg::NIBBLE_W-1:0] macTxNibble,
  input wire logic macTxEnable,
  input wire logic macTxError,
  output logic macTxTake,
  // receive to the user
  output logic [mpdp_pkg::NIBBLE_W-1:0] macRxNibble,
  output logic macRxValid,
  output logic macRxError,
  output logic macRxStrobe,
  output logic macCollision,
  output logic macCarrierSense
);
  import mpdp_pkg::*;

  logic [NIBBLE_W-1:0] txNibble;
  logic txEnable;
  logic txError;
  logic [2:0] txClkSync;
  logic [2:0] rxClkSync;
  logic [NIBBLE_W-1:0] rxNibbleMeta;
  logic [NIBBLE_W-1:0] rxNibbleSync;
  logic [1:0] rxFlagMeta;
  logic [1:0] rxFlagSync;
  logic colMeta;
  logic crsMeta;
  logic txRise;
  logic rxRise;

  assign link.portTxNibble = txNibble;
  assign link.portTxEnable = txEnable;
  assign link.portTxError = txError;

  ////////////////////////////////////////////////////////////////////////////
  // link pin synchronisers

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      txClkSync <= 3'h0;
      rxClkSync <= 3'h0;
      rxNibbleMeta <= IDLE_NIBBLE;
      rxNibbleSync <= IDLE_NIBBLE;
      rxFlagMeta <= 2'h0;
      rxFlagSync <= 2'h0;
      colMeta <= 1'h0;
      crsMeta <= 1'h0;
      macCollision <= 1'h0;
      macCarrierSense <= 1'h0;
    end else begin
      txClkSync <= {txClkSync[1:0], link.portTxClock};
      rxClkSync <= {rxClkSync[1:0], link.portRxClock};
      rxNibbleMeta <= link.portRxNibble;
      rxNibbleSync <= rxNibbleMeta;
      rxFlagMeta <= {link.portRxValid, link.portRxError};
      rxFlagSync <= rxFlagMeta;
      colMeta <= link.portCollision;
      macCollision <= colMeta;
      crsMeta <= link.portCarrierSense;
      macCarrierSense <= crsMeta;
    end
  end

  assign txRise = txClkSync[1] && !txClkSync[2];
  assign rxRise = rxClkSync[1] && !rxClkSync[2];

  ////////////////////////////////////////////////////////////////////////////
  // transmit pins

  // pins move only just after a rising tx clock
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      txNibble <= IDLE_NIBBLE;
      txEnable <= 1'h0;
      txError <= 1'h0;
      macTxTake <= 1'h0;
    end else begin
      macTxTake <= txRise;
      if (txRise) begin
        txNibble <= macTxNibble;
        txEnable <= macTxEnable;
        txError <= macTxEnable && macTxError;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive capture

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      macRxNibble <= IDLE_NIBBLE;
      macRxValid <= 1'h0;
      macRxError <= 1'h0;
      macRxStrobe <= 1'h0;
    end else begin
      macRxStrobe <= rxRise;
      if (rxRise) begin
        macRxNibble <= rxNibbleSync;
        macRxValid <= rxFlagSync[1];
        macRxError <= rxFlagSync[0];
      end
    end
  end

endmodule : mpdp_mac_end

// >>> tb/mpdp_chk.sv
// Purpose: concurrent checks on the pins between the two ends
// Assumes: both ends run on core_clk with resetn async low
// Notes: sees the interface signals only
`timescale 1ns/1ps
module mpdp_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // pins
  input wire logic portTxClock,
  input wire logic [mpdp_pkg::NIBBLE_W-1:0] portTxNibble,
  input wire logic portTxEnable,
  input wire logic portTxError,
  input wire logic portRxClock,
  input wire logic [mpdp_pkg::NIBBLE_W-1:0] portRxNibble,
  input wire logic portRxValid,
  input wire logic portRxError,
  input wire logic portCollision,
  input wire logic portCarrierSense
);
  import mpdp_pkg::*;
  ////////////////////////////////////////
  // length of each tx clock level
  logic prevClk;
  logic seen;
  logic [5:0] lvl;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      prevClk <= 1'h0;
      seen <= 1'h0;
      lvl <= 6'h00;
    end else begin
      prevClk <= portTxClock;
      seen <= seen | (portTxClock != prevClk);
      lvl <= (portTxClock != prevClk) ? 6'h01 : lvl + 6'h01;
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  AST_TX_HALF: assert property ((seen && portTxClock != prevClk) |->
    (lvl == HALF_FAST || lvl == HALF_SLOW)) else $error("tx clock level length wrong");
  AST_RX_PHASE: assert property (portRxClock == portTxClock)
    else $error("rx clock not with tx clock");
  AST_RX_NIB_EDGE: assert property ($changed(portRxNibble) |-> $fell(portRxClock))
    else $error("rx nibble off the clock fall");
  AST_RX_VALID_EDGE: assert property ($changed(portRxValid) |-> $fell(portRxClock))
    else $error("rx valid off the clock fall");
  AST_RX_ERR_EDGE: assert property ($changed(portRxError) |-> $fell(portRxClock))
    else $error("rx error off the clock fall");
  AST_RX_IDLE_NIB: assert property (!portRxValid |-> portRxNibble == IDLE_NIBBLE)
    else $error("rx nibble shown without valid");
  AST_TX_NIB_EDGE: assert property ($changed(portTxNibble) |-> portTxClock &&
    $past(portTxClock, 3) && !$past(portTxClock, 4)) else $error("tx nibble off step");
  AST_TX_EN_EDGE: assert property ($changed(portTxEnable) |-> portTxClock &&
    $past(portTxClock, 3) && !$past(portTxClock, 4)) else $error("tx enable off step");
  AST_TX_ERR_EN: assert property (portTxError |-> portTxEnable)
    else $error("tx error without enable");
  cover property ($rose(portRxValid));
  cover property ($rose(portTxError));
  cover property ($rose(portCollision));
  cover property ($rose(portCarrierSense));
endmodule : mpdp_chk

// >>> tb/tb_mii_port_data_path.sv
// Purpose: both ends joined, user sides driven and compared
// Assumes: speed is changed only while reset is held
// Notes: expectations queued by the drivers, popped at each result strobe
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin failCount++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module tb_mii_port_data_path;
  import mpdp_pkg::*;
  logic core_clk = 1'h0;
  logic resetn = 1'h0;
  logic speed100 = 1'h1;
  logic fullDuplex = 1'h0;
  logic macTxEnable = 1'h0;
  logic macTxError = 1'h0;
  logic lineRxValid = 1'h0;
  logic lineRxSymbolError = 1'h0;
  logic lineRxActive = 1'h0;
  logic lineCollision = 1'h0;
  logic [NIBBLE_W-1:0] macTxNibble = 4'h0;
  logic [NIBBLE_W-1:0] lineRxNibble = 4'h0;
  logic [NIBBLE_W-1:0] lineTxNibble, macRxNibble;
  logic lineTxValid, lineTxHalt, lineTxStrobe, lineRxTake, macTxTake;
  logic macRxValid, macRxError, macRxStrobe, macCollision, macCarrierSense;
  logic [5:0] txQ[$];
  logic [5:0] rxQ[$];
  logic [5:0] txEx, rxEx;
  logic [31:0] tr, rr;
  logic tEn, tEr;
  int seed = 75081;
  int txMode = 0;
  int cycles = 0;
  int failCount = 0;
  int comparisons = 0;
  int txSeen = 0;
  int rxSeen = 0;
  ////////////////////////////////////////
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  mpdp_if link();
  mpdp_phy_end i_mpdp_phy_end (.core_clk(core_clk), .resetn(resetn), .link(link),
    .speed100(speed100), .fullDuplex(fullDuplex), .lineTxNibble(lineTxNibble),
    .lineTxValid(lineTxValid), .lineTxHalt(lineTxHalt), .lineTxStrobe(lineTxStrobe),
    .lineRxNibble(lineRxNibble), .lineRxValid(lineRxValid),
    .lineRxSymbolError(lineRxSymbolError), .lineRxActive(lineRxActive),
    .lineCollision(lineCollision), .lineRxTake(lineRxTake));
  mpdp_mac_end i_mpdp_mac_end (.core_clk(core_clk), .resetn(resetn), .link(link),
    .macTxNibble(macTxNibble), .macTxEnable(macTxEnable), .macTxError(macTxError),
    .macTxTake(macTxTake), .macRxNibble(macRxNibble), .macRxValid(macRxValid),
    .macRxError(macRxError), .macRxStrobe(macRxStrobe), .macCollision(macCollision),
    .macCarrierSense(macCarrierSense));
  mpdp_chk i_mpdp_chk (.core_clk(core_clk), .resetn(resetn),
    .portTxClock(link.portTxClock), .portTxNibble(link.portTxNibble),
    .portTxEnable(link.portTxEnable), .portTxError(link.portTxError),
    .portRxClock(link.portRxClock), .portRxNibble(link.portRxNibble),
    .portRxValid(link.portRxValid), .portRxError(link.portRxError),
    .portCollision(link.portCollision), .portCarrierSense(link.portCarrierSense));
  ////////////////////////////////////////
  // drivers: new values once the previous ones were taken
  always @(negedge core_clk) begin
    if (resetn && macTxTake === 1'h1) begin
      tr = $random(seed);
      tEn = (txMode == 2) || (txMode == 1 && tr[4]);
      tEr = tEn && tr[5];
      macTxNibble <= tr[3:0];
      macTxEnable <= tEn;
      macTxError <= tEr;
      txQ.push_back({tEn & tEr & speed100, tEn, tEn ? tr[3:0] : IDLE_NIBBLE});
    end
    if (resetn && lineRxTake === 1'h1) begin
      rr = $random(seed);
      lineRxNibble <= rr[3:0];
      lineRxValid <= rr[4];
      lineRxSymbolError <= rr[5] & rr[6];
      rxQ.push_back({rr[5] & rr[6], rr[4], rr[4] ? rr[3:0] : IDLE_NIBBLE});
    end
  end
  // monitors
  always @(negedge core_clk) begin
    if (resetn && lineTxStrobe === 1'h1 && txQ.size() > 0) begin
      txEx = txQ.pop_front();
      txSeen++;
      `CHK("line tx", txEx, {lineTxHalt, lineTxValid, lineTxNibble})
    end
    if (resetn && macRxStrobe === 1'h1 && rxQ.size() > 0) begin
      rxEx = rxQ.pop_front();
      rxSeen++;
      `CHK("user rx", rxEx, {macRxError, macRxValid, macRxNibble})
    end
  end
  ////////////////////////////////////////
  task automatic doReset(input logic spd);
    @(posedge core_clk);
    #1;
    resetn = 1'h0;
    txMode = 0;
    speed100 = spd;
    {fullDuplex, lineRxActive, lineCollision} = 3'h0;
    {macTxNibble, macTxEnable, macTxError} = 6'h00;
    {lineRxNibble, lineRxValid, lineRxSymbolError} = 6'h00;
    txQ = '{6'h00, 6'h00};
    rxQ = '{6'h00, 6'h00};
    repeat (16) @(negedge core_clk);
    resetn = 1'h1;
  endtask : doReset
  task automatic finalReport();
    $display("comparisons %0d mismatches %0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finalReport
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failCount++;
      finalReport();
    end
  end
  ////////////////////////////////////////
  initial begin
    doReset(1'h1);
    txMode = 1;
    repeat (2000) @(negedge core_clk);
    // collision and carrier over duplex, rx activity and tx enable
    for (int i = 0; i < 16; i++) begin
      txMode = i[3] ? 2 : 0;
      {fullDuplex, lineRxActive, lineCollision} = i[2:0];
      repeat (40) @(negedge core_clk);
      `CHK("collision", i[0] & ~i[2], macCollision)
      `CHK("carrier", i[1] | (i[3] & ~i[2]), macCarrierSense)
    end
    doReset(1'h0);
    txMode = 1;
    repeat (8000) @(negedge core_clk);
    // both paths must have delivered a steady stream of results
    `CHK("tx results", 1'h1, txSeen > 100)
    `CHK("rx results", 1'h1, rxSeen > 100)
    finalReport();
  end
endmodule : tb_mii_port_data_path
